// file: src/acq_start_trigger_ctrl.sv
// Purpose: arm camera for frame bursts on acquisition-start triggers
// Assumes: 20 MHz ref_clk, host register port, frame triggers from same clock
// Notes: frame_start_in is a one-cycle pulse from the frame trigger logic
`timescale 1ns/1ps
`default_nettype none
module acq_start_trigger_ctrl
    import arm_trig_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Hardware trigger lines
    input  wire logic       ext_arm_trigger_in,
    input  wire logic       line2_in,
    // Frame trigger from frame-start logic
    input  wire logic       frame_start_in,
    // To acquisition engine
    output logic            frame_begin,
    output logic            armed,
    output logic            wait_arm
);

    logic [7:0]  ctrl;
    logic [7:0]  burst;
    logic [7:0]  frame_cnt;
    arm_state_t  state;
    arm_state_t  next_state;
    logic        line1_edge;
    logic        line2_edge;
    logic        hw_edge;
    logic        sw_trig;
    logic        acq_start;
    logic        acq_stop;
    logic        arm_trig;
    logic        frame_ok;
    logic        burst_done;
    logic        cmd_wr;

    // Line 1 and line 2 each get their own synchroniser
    line_edge_detect u_line1
    (
        .clk        (ref_clk),
        .arst_n     (arst_n),
        .line_in    (ext_arm_trigger_in),
        .falling    (ctrl[CTRL_FALLING]),
        .edge_pulse (line1_edge)
    );

    line_edge_detect u_line2
    (
        .clk        (ref_clk),
        .arst_n     (arst_n),
        .line_in    (line2_in),
        .falling    (ctrl[CTRL_FALLING]),
        .edge_pulse (line2_edge)
    );

    // Control register; legacy mode and line 2 out of reset
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            ctrl <= CTRL_RESET;
        else if (reg_wr && reg_addr == REG_CTRL)
            ctrl <= reg_wdata;
    end

    // Burst length; zero writes are clamped to one since 0 would end a burst only after 256 frames
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            burst <= BURST_RESET;
        else if (reg_wr && reg_addr == REG_BURST)
            burst <= (reg_wdata < BURST_MIN) ? BURST_MIN : reg_wdata;
    end

    // Command decode
    assign cmd_wr    = reg_wr && reg_addr == REG_CMD;
    assign acq_start = cmd_wr && reg_wdata[CMD_ACQ_START];
    assign acq_stop  = cmd_wr && reg_wdata[CMD_ACQ_STOP];
    // Software trigger counts only while the selector points at this trigger
    assign sw_trig   = cmd_wr && reg_wdata[CMD_SW_TRIG] && ctrl[CTRL_TGT_ARM];

    // Line select: clear bit picks line 1
    assign hw_edge   = ctrl[CTRL_LINE_SEL] ? line2_edge : line1_edge;

    // Trigger source mux
    always_comb
    begin
        if (!ctrl[CTRL_TRIG_ON])
            arm_trig = 1'b1;
        else if (ctrl[CTRL_SRC_HW])
            arm_trig = hw_edge;
        else
            arm_trig = sw_trig;
    end

    assign frame_ok   = state == ST_WAIT_FRAME && frame_start_in;
    assign burst_done = frame_ok && ctrl[CTRL_TRIG_ON] && (frame_cnt + 8'h01 == burst);

    // State transitions
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_STOPPED:
            begin
                // Arming needs standard mode, continuous mode and a start command
                if (acq_start && ctrl[CTRL_STD_MODE] && ctrl[CTRL_ACQ_CONT])
                    next_state = ST_WAIT_ARM;
            end
            ST_WAIT_ARM:
            begin
                if (acq_stop || !ctrl[CTRL_STD_MODE])
                    next_state = ST_STOPPED;
                else if (arm_trig)
                    next_state = ST_WAIT_FRAME;
            end
            ST_WAIT_FRAME:
            begin
                if (acq_stop || !ctrl[CTRL_STD_MODE])
                    next_state = ST_STOPPED;
                else if (burst_done)
                    next_state = ST_WAIT_ARM;
            end
            default:
                next_state = ST_STOPPED;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            state <= ST_STOPPED;
        else
            state <= next_state;
    end

    // Frames accepted since arming
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            frame_cnt <= 8'h00;
        else if (state != ST_WAIT_FRAME || burst_done)
            frame_cnt <= 8'h00;
        else if (frame_ok)
            frame_cnt <= frame_cnt + 8'h01;
    end

    // Registered outputs to the engine
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            frame_begin <= 1'b0;
            armed       <= 1'b0;
            wait_arm    <= 1'b0;
        end
        else
        begin
            frame_begin <= frame_ok;
            armed       <= next_state == ST_WAIT_FRAME;
            wait_arm    <= next_state == ST_WAIT_ARM;
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                REG_CTRL:   reg_rdata <= ctrl;
                REG_BURST:  reg_rdata <= burst;
                REG_STATUS: reg_rdata <= {frame_cnt[5:0], state == ST_WAIT_FRAME, state == ST_WAIT_ARM};
                default:    reg_rdata <= 8'h00;
            endcase
        end
        else
            reg_rdata <= 8'h00;
    end

endmodule
`default_nettype wire

// file: src/arm_trig_pkg.sv
// Purpose: constants for the acquisition-start trigger control block
// Assumes: 20 MHz ref_clk, plain register port
// Notes:
package arm_trig_pkg;

    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_BURST  = 4'h4;
    localparam logic [3:0] REG_CMD    = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'hC;

    // Control fields
    localparam int CTRL_STD_MODE   = 0;
    localparam int CTRL_TRIG_ON    = 1;
    localparam int CTRL_SRC_HW     = 2;
    localparam int CTRL_FALLING    = 3;
    localparam int CTRL_ACQ_CONT   = 4;
    localparam int CTRL_TGT_ARM    = 5;
    localparam int CTRL_LINE_SEL   = 6;

    // Command fields, write one to execute
    localparam int CMD_SW_TRIG     = 0;
    localparam int CMD_ACQ_START   = 1;
    localparam int CMD_ACQ_STOP    = 2;

    localparam logic [7:0] CTRL_RESET  = 8'h40;
    localparam logic [7:0] BURST_RESET = 8'h01;
    localparam logic [7:0] BURST_MIN   = 8'h01;
    localparam logic [7:0] BURST_MAX   = 8'hFF;

    typedef enum logic [1:0] {
        ST_STOPPED,
        ST_WAIT_ARM,
        ST_WAIT_FRAME
    } arm_state_t;

endpackage

// file: src/line_edge_detect.sv
// Purpose: synchronise a trigger line and emit one pulse per edge of the selected polarity
// Assumes: line is asynchronous to clk
// Notes: two flops before any logic reads the line
`timescale 1ns/1ps
`default_nettype none
module line_edge_detect
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // Line and polarity
    input  wire logic line_in,
    input  wire logic falling,
    // Pulse out
    output logic      edge_pulse
);

    logic sync_a;
    logic sync_b;
    logic last_b;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            last_b <= 1'b0;
        end
        else
        begin
            sync_a <= line_in;
            sync_b <= sync_a;
            last_b <= sync_b;
        end
    end

    // Edge chosen by polarity
    always_comb
    begin
        if (falling)
            edge_pulse = last_b & ~sync_b;
        else
            edge_pulse = ~last_b & sync_b;
    end

endmodule
`default_nettype wire

// file: tb/acq_start_trigger_ctrl_props.sv
// Purpose: port checks on arming
// Assumes: CTRL and BURST shadowed from writes
// Notes: windows allow for the output flops
`timescale 1ns/1ps
`default_nettype none
module acq_start_trigger_ctrl_props
    import arm_trig_pkg::*;
(
    // Clock and register port
    input wire logic       ref_clk,
    input wire logic       arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    // Trigger and state
    input wire logic       ext_arm_trigger_in,
    input wire logic       frame_start_in,
    input wire logic       frame_begin,
    input wire logic       armed,
    input wire logic       wait_arm
);
    logic [7:0] ctrl, burst, fcnt;
    // Only trigger-on software arming; a stop in the same write wins over the trigger
    wire        sw = wait_arm && reg_wr && reg_addr == REG_CMD && reg_wdata[0] && !reg_wdata[2]
                     && ctrl[1] && !ctrl[2];
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            {ctrl, burst, fcnt} <= {CTRL_RESET, 16'h0100};
        else
        begin
            if (reg_wr && reg_addr == REG_CTRL)
                ctrl <= reg_wdata;
            // Zero burst is stored as one
            if (reg_wr && reg_addr == REG_BURST)
                burst <= reg_wdata | {7'h00, reg_wdata == 8'h00};
            fcnt <= armed ? fcnt + {7'h00, frame_start_in} : 8'h00;
        end
    sequence s_go;
        reg_wr && reg_addr == REG_CMD && reg_wdata[1] && ctrl[0] && ctrl[1] && ctrl[4];
    endsequence
    AST_START: assert property (s_go ##0 (!armed && !wait_arm) |-> ##[1:2] wait_arm)
        else $error("start gave no wait");
    AST_SW_ARM: assert property (sw && ctrl[5] |-> ##[1:2] armed)
        else $error("soft trigger did not arm");
    AST_SW_OFF: assert property (sw && !ctrl[5] |=> !armed [*2])
        else $error("soft trigger armed unselected");
    AST_HW_ARM: assert property (wait_arm && ctrl[1] && ctrl[2] && !ctrl[6] &&
        (ctrl[3] ? $fell(ext_arm_trigger_in) : $rose(ext_arm_trigger_in)) |-> ##[1:5] armed)
        else $error("line edge did not arm");
    AST_IGNORE: assert property (wait_arm && frame_start_in |=> !frame_begin)
        else $error("frame while waiting");
    AST_FRAME: assert property (armed && frame_start_in |=> frame_begin)
        else $error("frame lost");
    AST_BURST: assert property (armed && frame_start_in && ctrl[1] && fcnt == burst - 8'h01
        |-> ##[1:2] (wait_arm && !armed))
        else $error("burst did not end");
    AST_LEGACY: assert property (!ctrl[0] [*3] |-> !armed && !wait_arm)
        else $error("active in legacy");
endmodule
bind acq_start_trigger_ctrl acq_start_trigger_ctrl_props props_u (.ref_clk, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .ext_arm_trigger_in, .frame_start_in, .frame_begin, .armed, .wait_arm);
`default_nettype wire

// file: tb/acq_start_trigger_ctrl_tb.sv
// Purpose: bench for acquisition-start arming
// Assumes: inputs change on the rising edge
// Notes: status read on its two state bits
`timescale 1ns/1ps
`default_nettype none
module acq_start_trigger_ctrl_tb;
    import arm_trig_pkg::*;
    logic       ref_clk, arst_n, reg_wr, reg_rd, frame_start_in, frame_begin, armed, wait_arm, l1, l2;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    int         error_cnt = 0, comparisons = 0;
    acq_start_trigger_ctrl dut_u (.ref_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .ext_arm_trigger_in(l1), .line2_in(l2), .frame_start_in, .frame_begin, .armed, .wait_arm);
    ext_line_model line_u (.ref_clk(ref_clk), .line1(l1), .line2(l2));
    initial
    begin
        ref_clk = 1'b0;
        forever
            #25 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Read data stand one cycle, so take them mid-cycle
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, v};
        @(posedge ref_clk);
        {reg_wr, reg_rd} <= 2'b00;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask
    task automatic st(input logic [7:0] e);
        bus(1'b0, REG_STATUS, 8'h00);
        check(d & 8'h03, e);
    endtask
    task automatic frame(input logic e);
        @(posedge ref_clk);
        frame_start_in <= 1'b1;
        @(posedge ref_clk);
        frame_start_in <= 1'b0;
        @(negedge ref_clk);
        check({7'h00, frame_begin}, {7'h00, e});
    endtask
    task automatic go(input logic [7:0] c, input logic [7:0] n);
        bus(1'b1, REG_CTRL, c);
        bus(1'b1, REG_BURST, n);
        bus(1'b1, REG_CMD, 8'h02);
    endtask
    task automatic t_reset;
        bus(1'b0, REG_CTRL, 8'h00);
        check(d, 8'h40);
        bus(1'b0, 4'h2, 8'h00);
        check(d, 8'h00);
        st(8'h00);
        $display("reset test done");
    endtask
    task automatic t_soft;
        go(8'h13, 8'h03);
        bus(1'b1, REG_CMD, 8'h01);
        st(8'h01);
        bus(1'b1, REG_CTRL, 8'h33);
        frame(1'b0);
        bus(1'b1, REG_CMD, 8'h01);
        st(8'h02);
        repeat (3) frame(1'b1);
        st(8'h01);
        bus(1'b1, REG_CMD, 8'h01);
        st(8'h02);
        bus(1'b1, REG_CMD, 8'h04);
        $display("soft test done");
    endtask
    task automatic t_hw;
        for (int p = 0; p < 2; p++)
        begin
            go(8'h37 | {4'h0, p[0], 3'h0}, 8'h01);
            line_u.drive(!p[0]);
            st(8'h02);
            frame(1'b1);
            line_u.drive(p[0]);
            st(8'h01);
            line_u.drive(!p[0]);
            st(8'h02);
            bus(1'b1, REG_CMD, 8'h04);
        end
        // Line 2 selected: line 1 edges must not arm
        go(8'h77, 8'h01);
        line_u.drive(1'b1);
        st(8'h01);
        line_u.drive2(1'b1);
        st(8'h02);
        bus(1'b1, REG_CMD, 8'h04);
        $display("hw test done");
    endtask
    task automatic t_free;
        bus(1'b1, REG_BURST, 8'h00);
        bus(1'b0, REG_BURST, 8'h00);
        check(d, 8'h01);
        go(8'h11, 8'h01);
        st(8'h02);
        repeat (2) frame(1'b1);
        st(8'h02);
        bus(1'b1, REG_CTRL, 8'h10);
        bus(1'b1, REG_CMD, 8'h02);
        st(8'h00);
        $display("free test done");
    endtask
    task automatic summarize;
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        {arst_n, reg_wr, reg_rd, frame_start_in, reg_addr, reg_wdata} = '0;
        repeat (16) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_reset;
        t_soft;
        t_hw;
        t_free;
        summarize;
    end
    // Run needs well under 1000 cycles
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        summarize;
    end
endmodule
`default_nettype wire

// file: tb/ext_line_model.sv
// Purpose: external trigger line source
// Assumes: levels change after a clock edge
// Notes: line 2 idles low
`timescale 1ns/1ps
`default_nettype none
module ext_line_model
(
    // Clock in, lines out
    input  wire logic ref_clk,
    output var logic  line1 = 1'b0,
    output var logic  line2 = 1'b0
);
    // Held long enough to pass the synchroniser
    task automatic drive(input logic v);
        @(posedge ref_clk);
        line1 <= v;
        repeat (6) @(posedge ref_clk);
    endtask
    task automatic drive2(input logic v);
        @(posedge ref_clk);
        line2 <= v;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire
